// File: rdvd_dest_decode.sv
`timescale 1ns/1ps

module rdvd_dest_decode (
  input  wire logic [63:0]         entry,
  input  wire rdvd_pkg::rdvd_mode_t mode,
  output logic [31:0]              target_cpu_identifier,
  output logic                     dest_rsvd_bad,
  output logic                     mode_bad
);

  logic [15:0] up_bits;
  logic [7:0]  mid_bits;
  logic [7:0]  bot_bits;

  assign up_bits  = entry[rdvd_pkg::DEST_UP_HI:rdvd_pkg::DEST_UP_LO];
  assign mid_bits = entry[rdvd_pkg::DEST_MID_HI:rdvd_pkg::DEST_MID_LO];
  assign bot_bits = entry[rdvd_pkg::DEST_BOT_HI:rdvd_pkg::DEST_BOT_LO];

  // ==========================================================
  // Layout per addressing mode
  always_comb
  begin
    target_cpu_identifier = rdvd_pkg::RST_DEST;
    dest_rsvd_bad         = 1'b0;
    mode_bad              = 1'b0;
    case (mode)
      rdvd_pkg::RDVD_MODE_CLUSTER:
      begin
        target_cpu_identifier = {24'h00_0000,
          entry[rdvd_pkg::CLU_HI_HI:rdvd_pkg::CLU_HI_LO],
          entry[rdvd_pkg::CLU_LO_HI:rdvd_pkg::CLU_LO_LO]};
        dest_rsvd_bad = (|up_bits) | (|bot_bits);
      end
      rdvd_pkg::RDVD_MODE_FLAT, rdvd_pkg::RDVD_MODE_PHYSICAL:
      begin
        target_cpu_identifier = {24'h00_0000, mid_bits};
        dest_rsvd_bad = (|up_bits) | (|bot_bits);
      end
      rdvd_pkg::RDVD_MODE_EXTENDED:
      begin
        // Whole field is the identifier, nothing reserved
        target_cpu_identifier =
          entry[rdvd_pkg::DEST_HI:rdvd_pkg::DEST_LO];
      end
      rdvd_pkg::RDVD_MODE_ALT:
      begin
        target_cpu_identifier = {16'h0000, mid_bits, bot_bits};
        dest_rsvd_bad = |up_bits;
      end
      default:
      begin
        mode_bad = 1'b1;
      end
    endcase
  end

endmodule // rdvd_dest_decode

// File: rdvd_irq_sink.sv
`timescale 1ns/1ps

// ==========================================================
// Local controller stand-in, counts delivered present results
module rdvd_irq_sink (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   rsp_valid,
  input  wire rdvd_pkg::rdvd_result_t rsp,
  output logic [7:0]                  n_recv_q
);
  // Only sees mclk, so the bench never stalls clken under a valid
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      n_recv_q <= 8'h00;
    else if (rsp_valid && rsp.present)
      n_recv_q <= n_recv_q + 8'h01;
  end
endmodule // rdvd_irq_sink

// File: rdvd_pkg.sv
package rdvd_pkg;

  // ==========================================================
  // Entry layout, lower 64 bits
  localparam int unsigned ENTRY_W      = 64;
  localparam int unsigned PRESENT_BIT  = 0;
  localparam int unsigned DEST_HI      = 63;
  localparam int unsigned DEST_LO      = 32;
  localparam int unsigned DEST_UP_HI   = 63;
  localparam int unsigned DEST_UP_LO   = 48;
  localparam int unsigned DEST_MID_HI  = 47;
  localparam int unsigned DEST_MID_LO  = 40;
  localparam int unsigned CLU_HI_HI    = 47;
  localparam int unsigned CLU_HI_LO    = 44;
  localparam int unsigned CLU_LO_HI    = 43;
  localparam int unsigned CLU_LO_LO    = 40;
  localparam int unsigned DEST_BOT_HI  = 39;
  localparam int unsigned DEST_BOT_LO  = 32;
  localparam int unsigned RSV_HI_HI    = 31;
  localparam int unsigned RSV_HI_LO    = 24;
  localparam int unsigned VEC_HI       = 23;
  localparam int unsigned VEC_LO       = 16;
  localparam int unsigned RSV_MID_HI   = 15;
  localparam int unsigned RSV_MID_LO   = 12;
  localparam int unsigned SW_HI        = 11;
  localparam int unsigned SW_LO        = 8;

  // ==========================================================
  // Widths and reset values
  localparam int unsigned DEST_W       = 32;
  localparam int unsigned VEC_W        = 8;
  localparam int unsigned CNT_W        = 8;
  localparam logic [31:0] RST_DEST     = 32'h0000_0000;
  localparam logic [7:0]  RST_VEC      = 8'h00;
  localparam logic [7:0]  RST_CNT      = 8'h00;
  localparam logic [7:0]  CNT_MAX      = 8'hff;

  // ==========================================================
  // Addressing modes
  typedef enum logic [4:0] {
    RDVD_MODE_CLUSTER  = 5'h01,
    RDVD_MODE_FLAT     = 5'h02,
    RDVD_MODE_PHYSICAL = 5'h04,
    RDVD_MODE_EXTENDED = 5'h08,
    RDVD_MODE_ALT      = 5'h10
  } rdvd_mode_t;

  typedef struct packed {
    logic        present;
    logic        rsvd_fault;
    logic        mode_fault;
    logic [31:0] target_cpu_identifier;
    logic [7:0]  vector;
  } rdvd_result_t;

endpackage : rdvd_pkg

// File: rdvd_top.sv
`timescale 1ns/1ps

module rdvd_top #(
  parameter int unsigned ENTRY_W = rdvd_pkg::ENTRY_W,
  parameter int unsigned CNT_W   = rdvd_pkg::CNT_W
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  clken,
  input  wire logic                  req_valid,
  input  wire logic [ENTRY_W-1:0]    req_entry,
  input  wire rdvd_pkg::rdvd_mode_t  mode_cfg,
  output logic                       rsp_valid,
  output rdvd_pkg::rdvd_result_t     rsp,
  output logic [CNT_W-1:0]           fault_count
);

  logic                   present;
  logic [31:0]            dec_dest;
  logic                   dest_rsvd_bad;
  logic                   mode_bad;
  logic                   low_rsvd_bad;
  logic                   any_fault;
  logic                   take;
  rdvd_pkg::rdvd_result_t rsp_d;
  rdvd_pkg::rdvd_result_t rsp_q;
  logic                   rsp_valid_q;
  logic [CNT_W-1:0]       fault_count_q;

  // ==========================================================
  // Parameter checks
  // Field positions are fixed, and the ceiling is an 8-bit constant
  if (ENTRY_W != rdvd_pkg::ENTRY_W)
  begin : g_bad_entry_w
    $error("ENTRY_W must equal the entry layout width");
  end
  if (CNT_W != rdvd_pkg::CNT_W)
  begin : g_bad_cnt_w
    $error("CNT_W must match the fault count ceiling");
  end

  assign take    = req_valid & clken;
  assign present = req_entry[rdvd_pkg::PRESENT_BIT];

  rdvd_dest_decode u_decode (
    .entry                 (req_entry),
    .mode                  (mode_cfg),
    .target_cpu_identifier (dec_dest),
    .dest_rsvd_bad         (dest_rsvd_bad),
    .mode_bad              (mode_bad)
  );

  // ==========================================================
  // Result formation
  // Reserved checks only count for present entries; software-owned
  // bits 11:8 are never read here.
  assign low_rsvd_bad =
    (|req_entry[rdvd_pkg::RSV_HI_HI:rdvd_pkg::RSV_HI_LO]) |
    (|req_entry[rdvd_pkg::RSV_MID_HI:rdvd_pkg::RSV_MID_LO]);
  assign any_fault = present & (low_rsvd_bad | dest_rsvd_bad | mode_bad);

  always_comb
  begin
    rsp_d                       = '0;
    rsp_d.present               = present;
    if (present)
    begin
      rsp_d.target_cpu_identifier = dec_dest;
      rsp_d.vector =
        req_entry[rdvd_pkg::VEC_HI:rdvd_pkg::VEC_LO];
      rsp_d.rsvd_fault = low_rsvd_bad | dest_rsvd_bad;
      rsp_d.mode_fault = mode_bad;
    end
  end

  // ==========================================================
  // Response registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_q <= '{present: 1'b0, rsvd_fault: 1'b0, mode_fault: 1'b0,
                 target_cpu_identifier: rdvd_pkg::RST_DEST,
                 vector: rdvd_pkg::RST_VEC};
    end
    else if (take)
    begin
      rsp_q <= rsp_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid_q <= 1'b0;
    end
    else if (clken)
    begin
      rsp_valid_q <= req_valid;
    end
  end

  // Saturates so software sees "many" instead of a wrapped small count
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_count_q <= rdvd_pkg::RST_CNT;
    end
    else if (take && any_fault && fault_count_q != rdvd_pkg::CNT_MAX)
    begin
      fault_count_q <= fault_count_q + 8'h01;
    end
  end

  assign rsp_valid   = rsp_valid_q;
  assign rsp         = rsp_q;
  assign fault_count = fault_count_q;

  // ==========================================================
  // Checks
  a_rsp_latency: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take |=> rsp_valid && rsp.present == $past(present))
    else $error("response missing one cycle after request");

  a_absent_quiet: assert property (
    @(posedge mclk) disable iff (!reset_n)
    rsp_valid && !rsp.present |->
      rsp.target_cpu_identifier == 32'h0000_0000 && rsp.vector == 8'h00 &&
      !rsp.rsvd_fault && !rsp.mode_fault)
    else $error("non-present entry produced a destination");

  a_cluster_dest: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && mode_cfg == rdvd_pkg::RDVD_MODE_CLUSTER |=>
      rsp.target_cpu_identifier[7:4] == $past(req_entry[47:44]) &&
      rsp.target_cpu_identifier[3:0] == $past(req_entry[43:40]) &&
      rsp.target_cpu_identifier[31:8] == 24'h00_0000)
    else $error("cluster destination mismatch");

  a_flat_dest: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && mode_cfg == rdvd_pkg::RDVD_MODE_FLAT |=>
      rsp.target_cpu_identifier == {24'h00_0000, $past(req_entry[47:40])})
    else $error("flat destination mismatch");

  a_phys_dest: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && mode_cfg == rdvd_pkg::RDVD_MODE_PHYSICAL |=>
      rsp.target_cpu_identifier == {24'h00_0000, $past(req_entry[47:40])})
    else $error("physical destination mismatch");

  a_ext_dest: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && mode_cfg == rdvd_pkg::RDVD_MODE_EXTENDED |=>
      rsp.target_cpu_identifier == $past(req_entry[63:32]))
    else $error("extended destination mismatch");

  a_alt_dest: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && mode_cfg == rdvd_pkg::RDVD_MODE_ALT |=>
      rsp.target_cpu_identifier ==
        {16'h0000, $past(req_entry[47:40]), $past(req_entry[39:32])})
    else $error("alternate destination mismatch");

  a_dest_rsvd: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present &&
      (mode_cfg == rdvd_pkg::RDVD_MODE_CLUSTER ||
       mode_cfg == rdvd_pkg::RDVD_MODE_FLAT ||
       mode_cfg == rdvd_pkg::RDVD_MODE_PHYSICAL) &&
      (req_entry[63:48] != 16'h0000 || req_entry[39:32] != 8'h00) |=>
      rsp.rsvd_fault)
    else $error("reserved destination bits set but no fault");

  a_vector_take: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present |=> rsp.vector == $past(req_entry[23:16]))
    else $error("vector mismatch");

  a_rsvd_flag: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && (req_entry[31:24] != 8'h00 ||
      req_entry[15:12] != 4'h0) |=> rsp.rsvd_fault)
    else $error("reserved bits set but no fault");

  a_sw_ignored: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && mode_cfg == rdvd_pkg::RDVD_MODE_EXTENDED &&
      req_entry[31:24] == 8'h00 && req_entry[15:12] == 4'h0 |=>
      !rsp.rsvd_fault && !rsp.mode_fault)
    else $error("software-owned bits affected result");

  a_mode_fault: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && !$onehot(mode_cfg) |=>
      rsp.mode_fault && rsp.target_cpu_identifier == 32'h0000_0000)
    else $error("illegal mode not flagged");

  a_legal_mode: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && present && $onehot(mode_cfg) |=> !rsp.mode_fault)
    else $error("legal mode flagged as fault");

  // Stalled cycles must leave every output as it was
  a_clken_freeze: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !clken |=> $stable(rsp) && $stable(rsp_valid) && $stable(fault_count))
    else $error("state moved while clock enable low");

  a_rsp_hold: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !take |=> $stable(rsp) && $stable(fault_count))
    else $error("response changed without a request");

  a_fault_step: assert property (
    @(posedge mclk) disable iff (!reset_n)
    take && any_fault && fault_count != rdvd_pkg::CNT_MAX |=>
      fault_count == $past(fault_count) + 8'h01)
    else $error("fault count did not advance");

endmodule // rdvd_top

// File: rdvd_top_bench.sv
`timescale 1ns/1ps

module rdvd_top_bench;
  logic                   mclk      = 1'b0;
  logic                   reset_n   = 1'b0;
  logic                   clken     = 1'b1;
  logic                   req_valid = 1'b0;
  logic [63:0]            req_entry = 64'h0;
  rdvd_pkg::rdvd_mode_t   mode_cfg  = rdvd_pkg::RDVD_MODE_FLAT;
  logic                   rsp_valid;
  rdvd_pkg::rdvd_result_t rsp;
  logic [7:0]             fault_count;
  logic [7:0]             n_recv;
  logic [7:0]             exp_faults = 8'h00;
  logic [7:0]             exp_recv   = 8'h00;
  int                     fails      = 0;
  int                     n_tests    = 0;
  // ==========================================================
  // Stimulus table; rows 6, 7 and 9..11 carry reserved or mode faults; row 8 is not present
  logic [63:0] ents [11] = '{64'h0000_a500_0042_0001,
    64'h0000_3c00_0077_0f01, 64'h0000_7e00_00ff_0001,
    64'hdead_beef_0031_0001, 64'h0000_12ab_0020_0001,
    64'h0001_a500_0042_0001, 64'h1234_5678_0050_1001,
    64'hdead_beef_ffff_fffe, 64'h0000_a500_0042_0001,
    64'h0000_1100_0142_0001, 64'h0000_a5ff_0042_0001};
  logic [4:0]  mds  [11] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10,
    5'h01, 5'h08, 5'h08, 5'h03, 5'h02, 5'h01};

  always #12.5 mclk = ~mclk;

  rdvd_top DUT (.mclk(mclk), .reset_n(reset_n), .clken(clken),
    .req_valid(req_valid), .req_entry(req_entry), .mode_cfg(mode_cfg),
    .rsp_valid(rsp_valid), .rsp(rsp), .fault_count(fault_count));
  rdvd_irq_sink SINK (.mclk(mclk), .reset_n(reset_n),
    .rsp_valid(rsp_valid), .rsp(rsp), .n_recv_q(n_recv));

  // ==========================================================
  // Reference decode
  function automatic rdvd_pkg::rdvd_result_t model(logic [63:0] e,
                                                   logic [4:0] m);
    rdvd_pkg::rdvd_result_t r;
    r = '0;
    if (e[0])
    begin
      r.present = 1'b1;
      r.vector = e[23:16];
      r.rsvd_fault = |{e[31:24], e[15:12]};
      case (m)
        5'h01, 5'h02, 5'h04:
        begin
          r.target_cpu_identifier = {24'h000000, e[47:40]};
          r.rsvd_fault = r.rsvd_fault | (|{e[63:48], e[39:32]});
        end
        5'h08: r.target_cpu_identifier = e[63:32];
        5'h10:
        begin
          r.target_cpu_identifier = {16'h0000, e[47:32]};
          r.rsvd_fault = r.rsvd_fault | (|e[63:48]);
        end
        default: r.mode_fault = 1'b1;
      endcase
    end
    return r;
  endfunction

  // ==========================================================
  // Compare and access tasks
  task automatic stop_test();
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_rsp(input rdvd_pkg::rdvd_result_t g, e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp8(input logic [7:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic put(input logic [63:0] e, input logic [4:0] m);
    rdvd_pkg::rdvd_result_t r;
    r = model(e, m);
    req_valid = 1'b1;
    req_entry = e;
    mode_cfg = rdvd_pkg::rdvd_mode_t'(m);
    if (e[0])
      exp_recv = exp_recv + 8'h01;
    if (r.rsvd_fault || r.mode_fault)
      exp_faults = exp_faults + 8'h01;
    @(negedge mclk);
  endtask

  task automatic get(input logic [63:0] e, input logic [4:0] m);
    int i;
    i = 0;
    req_valid = 1'b0;
    // Answer already stands when put returns; look before the next edge
    while (rsp_valid !== 1'b1 && i < 4)
    begin
      @(negedge mclk);
      i++;
    end
    if (i == 4)
    begin
      fails++;
      stop_test();
    end
    else
      cmp_rsp(rsp, model(e, m));
    // Keeps the next put's strobe out of this time step
    @(negedge mclk);
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    cmp8({7'h00, rsp_valid}, 8'h00);
    cmp8(fault_count, 8'h00);
    for (int k = 0; k < 11; k++)
    begin
      put(ents[k], mds[k]);
      get(ents[k], mds[k]);
    end
    // Stalled clock enable must not take the request
    @(negedge mclk);
    clken = 1'b0;
    put(ents[3], 5'h08);
    req_valid = 1'b0;
    clken = 1'b1;
    exp_recv = exp_recv - 8'h01;
    @(negedge mclk);
    cmp8({7'h00, rsp_valid}, 8'h00);
    cmp_rsp(rsp, model(ents[10], mds[10]));
    put(ents[1], 5'h02);
    cmp_rsp(rsp, model(ents[1], 5'h02));
    put(ents[4], 5'h10);
    req_valid = 1'b0;
    cmp8({7'h00, rsp_valid}, 8'h01);
    cmp_rsp(rsp, model(ents[4], 5'h10));
    repeat (2) @(negedge mclk);
    cmp8(fault_count, exp_faults);
    cmp8(n_recv, exp_recv);
    stop_test();
  end
endmodule // rdvd_top_bench
